/* File: pkg/hss_defs.svh */
// constants for the channel configuration register bank
`ifndef HSS_DEFS_SVH
`define HSS_DEFS_SVH

// serial word layout
`define HSS_WORD_W        16
`define HSS_BIT_WD        15
`define HSS_BIT_BANK      13
`define HSS_ADDR_HI       12
`define HSS_ADDR_LO       10
`define HSS_DATA_HI       8
`define HSS_SEL_HI        2
`define HSS_NM_STATE      1'b1
`define HSS_PF_STATE      1'b0

// register addresses (bits 12:10 of the word)
`define HSS_ADDR_STATUS   3'h0
`define HSS_ADDR_CHCFG    3'h2
`define HSS_ADDR_OCCFG    3'h4

// reset value of both configuration registers
`define HSS_CFG_RST       9'h000

// channel_config fields
`define HSS_CC_SHORT_DIS  8
`define HSS_CC_ONOL_DIS   7
`define HSS_CC_OFFOL_DIS  6
`define HSS_CC_DIR_DIS    5
`define HSS_CC_SLEW_HI    4
`define HSS_CC_SLEW_LO    3
`define HSS_CC_DLY_HI     2
`define HSS_CC_DLY_LO     0

// overcurrent_config fields
`define HSS_OC_RANGE      8
`define HSS_OC_PRESCALE   7
`define HSS_OC_CLK_INT    6
`define HSS_OC_RATIO      5
`define HSS_OC_HWIN       4
`define HSS_OC_MWIN       3
`define HSS_OC_UPPER      2
`define HSS_OC_MIDDLE     1
`define HSS_OC_LOWER      0

// external clock divider terminal counts (divide by 512 / 256)
`define HSS_DIV_LONG      9'h1ff
`define HSS_DIV_SHORT     9'h0ff

// lowest threshold level codes
`define HSS_OCL_HIGHEST   2'h1
`define HSS_OCL_MIDDLE    2'h2
`define HSS_OCL_LOWEST    2'h3

`endif

/* File: pkg/hss_pkg.sv */
// types shared by the channel configuration bank
`default_nettype none
package hss_pkg;

  typedef enum logic [1:0] {
    HSS_SLEW_LOW   = 2'b00,
    HSS_SLEW_MED   = 2'b01,
    HSS_SLEW_MEDHI = 2'b10,
    HSS_SLEW_HIGH  = 2'b11
  } hss_slew_type;

  typedef enum logic [1:0] {
    HSS_PH_IDLE = 2'b00,
    HSS_PH_HIGH = 2'b01,
    HSS_PH_MID  = 2'b10,
    HSS_PH_LOW  = 2'b11
  } hss_phase_type;

endpackage
`default_nettype wire

/* File: rtl/hss_spi_rx.sv */
// serial slave: 16-bit word in, readback word out
`timescale 1ns/1ps
`default_nettype none
`include "hss_defs.svh"

module hss_spi_rx (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // serial pins
  input  wire logic        csb_pin,
  input  wire logic        sclk_pin,
  input  wire logic        si_pin,
  output logic             so_out,
  output logic             so_oe,
  // word interface
  input  wire logic [15:0] tx_word,
  output logic [15:0]      rx_word,
  output logic             rx_valid
);

  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic [4:0]  cnt;
    logic [15:0] rx_word;
    logic        rx_valid;
    logic        so;
    logic        oe;
  } hss_spi_state_type;

  hss_spi_state_type r;
  hss_spi_state_type n;

  always_comb begin
    logic csb_fall;
    logic csb_rise;
    logic sck_rise;
    logic sck_fall;
    n = r;
    n.s1 = {csb_pin, sclk_pin, si_pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rx_valid = 1'b0;
    csb_fall = r.s3[2] & ~r.s2[2];
    csb_rise = ~r.s3[2] & r.s2[2];
    sck_rise = ~r.s3[1] & r.s2[1] & ~r.s2[2];
    sck_fall = r.s3[1] & ~r.s2[1] & ~r.s2[2];
    if (csb_fall) begin
      n.sh_out = tx_word;
      n.so = tx_word[15];
      n.oe = 1'b1;
      n.cnt = 5'h00;
    end
    if (sck_rise) begin
      n.sh_in = {r.sh_in[14:0], r.s2[0]};
      if (r.cnt != 5'h1f) begin
        n.cnt = r.cnt + 5'h01;
      end
    end
    if (sck_fall) begin
      n.sh_out = {r.sh_out[14:0], 1'b0};
      n.so = r.sh_out[14];
    end
    // only a frame of exactly 16 clocks is accepted
    if (csb_rise) begin
      n.oe = 1'b0;
      n.so = 1'b0;
      if (r.cnt == 5'h10) begin
        n.rx_word = r.sh_in;
        n.rx_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, cnt: 5'h00, default: '0};
    end else begin
      r <= n;
    end
  end

  assign so_out = r.so;
  assign so_oe = r.oe;
  assign rx_word = r.rx_word;
  assign rx_valid = r.rx_valid;

endmodule
`default_nettype wire

/* File: rtl/hss_chan_cfg.sv */
// per-channel configuration and overcurrent registers with their control logic
`timescale 1ns/1ps
`default_nettype none
`include "hss_defs.svh"

module hss_chan_cfg #(
  parameter int INT_DIV  = 50000,
  parameter int CW       = 20,
  parameter int T_OCH1   = 1000,
  parameter int T_OCH2   = 2000,
  parameter int T_OCM1_L = 4000,
  parameter int T_OCM2_L = 8000,
  parameter int T_OCM1_M = 4000,
  parameter int T_OCM2_M = 8000
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // serial pins
  input  wire logic        csb_pin,
  input  wire logic        sclk_pin,
  input  wire logic        si_pin,
  output logic             so_out,
  output logic             so_oe,
  // channel inputs
  input  wire logic        ext_clk_pin,
  input  wire logic [1:0]  direct_in_pin,
  input  wire logic [1:0]  load_type_config,
  input  wire logic [1:0]  pwm_on,
  // channel control outputs
  output logic [1:0]       chan_on,
  output logic [1:0]       short_detect_en,
  output logic [1:0]       on_openload_en,
  output logic [1:0]       off_openload_en,
  output logic [1:0][1:0]  slew_rate,
  // overcurrent and sense outputs
  output logic [1:0][1:0]  oc_phase,
  output logic [1:0]       upper_threshold_low,
  output logic [1:0]       middle_threshold_low,
  output logic [1:0][1:0]  lower_threshold_level,
  output logic [1:0]       sense_ratio_low,
  output logic [1:0]       sense_valid
);

  localparam int IDW = $clog2(INT_DIV);

  typedef struct packed {
    logic [1:0][8:0]    cc;
    logic [1:0][8:0]    oc;
    logic               rd_bank;
    logic [2:0]         rd_sel;
    logic [3:0]         soa;
    logic               wd;
    logic               ext1;
    logic               ext2;
    logic               ext3;
    logic [1:0]         dir1;
    logic [1:0]         dir2;
    logic [1:0]         cfg1;
    logic [1:0]         cfg2;
    logic [IDW-1:0]     idiv;
    logic [1:0][8:0]    ediv;
    logic [1:0]         tick;
    logic [1:0]         req;
    logic [1:0]         pend;
    logic [1:0]         on;
    logic [1:0][2:0]    dly;
    logic [1:0][1:0]    phase;
    logic [1:0][CW-1:0] wcnt;
    logic [1:0]         short_en;
    logic [1:0]         onol_en;
    logic [1:0]         offol_en;
    logic [1:0][1:0]    slew;
    logic [1:0]         och_low;
    logic [1:0]         ocm_low;
    logic [1:0][1:0]    ocl_lvl;
    logic [1:0]         ratio_low;
    logic [1:0]         sns_valid;
  } hss_cfg_state_type;

  hss_cfg_state_type r;
  hss_cfg_state_type n;
  logic [15:0]       tx_word;
  logic [15:0]       rx_word;
  logic              rx_valid;

  // window length less one, in system clock cycles
  function automatic logic [CW-1:0] win_len(input logic light, input logic hsel,
                                            input logic msel, input logic second);
    int t;
    t = 0;
    if (light) begin
      if (second) begin
        t = msel ? T_OCM2_L : T_OCM1_L;
      end else begin
        t = hsel ? T_OCH2 : T_OCH1;
      end
    end else begin
      unique case ({hsel, msel})
        2'b00: t = T_OCM1_M;
        2'b01: t = T_OCM2_M;
        2'b10: t = T_OCH1;
        2'b11: t = T_OCH2;
      endcase
    end
    return CW'(t - 1);
  endfunction

  function automatic logic [1:0] slew_map(input logic [1:0] code);
    logic [1:0] s;
    unique case (code)
      2'b00: s = hss_pkg::HSS_SLEW_MED;
      2'b01: s = hss_pkg::HSS_SLEW_LOW;
      2'b10: s = hss_pkg::HSS_SLEW_HIGH;
      2'b11: s = hss_pkg::HSS_SLEW_MEDHI;
    endcase
    return s;
  endfunction

  hss_spi_rx u_spi (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .csb_pin  (csb_pin),
    .sclk_pin (sclk_pin),
    .si_pin   (si_pin),
    .so_out   (so_out),
    .so_oe    (so_oe),
    .tx_word  (tx_word),
    .rx_word  (rx_word),
    .rx_valid (rx_valid)
  );

  // readback word built from the previous addressing transfer
  always_comb begin
    logic [8:0] data;
    data = 9'h000;
    if (r.rd_sel == `HSS_ADDR_CHCFG) begin
      data = r.cc[r.rd_bank];
    end else if (r.rd_sel == `HSS_ADDR_OCCFG) begin
      data = r.oc[r.rd_bank];
    end
    tx_word = {r.wd, `HSS_PF_STATE, r.soa, `HSS_NM_STATE, data};
  end

  always_comb begin
    logic       bank;
    logic       int_tick;
    logic       ext_rise;
    logic       ext_tick;
    logic       light;
    logic [8:0] lim;
    ext_tick = 1'b0;
    light = 1'b0;
    lim = 9'h000;
    n = r;
    bank = rx_word[`HSS_BIT_BANK];
    n.ext1 = ext_clk_pin;
    n.ext2 = r.ext1;
    n.ext3 = r.ext2;
    n.dir1 = direct_in_pin;
    n.dir2 = r.dir1;
    n.cfg1 = load_type_config;
    n.cfg2 = r.cfg1;
    ext_rise = r.ext2 & ~r.ext3;
    int_tick = (r.idiv == IDW'(INT_DIV - 1));
    n.idiv = int_tick ? '0 : r.idiv + IDW'(1);
    if (rx_valid) begin
      n.wd = rx_word[`HSS_BIT_WD];
      n.soa = {bank, rx_word[`HSS_SEL_HI:0]};
      // bank bit routes data to one copy
      // bank zero is channel 0, one is channel 1
      unique case (rx_word[`HSS_ADDR_HI:`HSS_ADDR_LO])
        `HSS_ADDR_CHCFG: n.cc[bank] = rx_word[`HSS_DATA_HI:0];
        `HSS_ADDR_OCCFG: n.oc[bank] = rx_word[`HSS_DATA_HI:0];
        `HSS_ADDR_STATUS: begin
          n.rd_bank = bank;
          n.rd_sel = rx_word[`HSS_SEL_HI:0];
        end
        default: ;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      lim = r.oc[c][`HSS_OC_PRESCALE] ? `HSS_DIV_LONG : `HSS_DIV_SHORT;
      ext_tick = 1'b0;
      if (ext_rise) begin
        if (r.ediv[c] >= lim) begin
          n.ediv[c] = 9'h000;
          ext_tick = 1'b1;
        end else begin
          n.ediv[c] = r.ediv[c] + 9'h001;
        end
      end
      n.tick[c] = r.oc[c][`HSS_OC_CLK_INT] ? int_tick : ext_tick;
      n.req[c] = r.cc[c][`HSS_CC_DIR_DIS] ? pwm_on[c] : r.dir2[c];
      if (!r.req[c]) begin
        n.on[c] = 1'b0;
        n.pend[c] = 1'b0;
      end else if (!r.on[c] && !r.pend[c]) begin
        n.pend[c] = 1'b1;
        n.dly[c] = r.cc[c][`HSS_CC_DLY_HI:`HSS_CC_DLY_LO];
      end else if (r.pend[c]) begin
        if (r.dly[c] == 3'h0) begin
          n.on[c] = 1'b1;
          n.pend[c] = 1'b0;
        end else if (r.tick[c]) begin
          n.dly[c] = r.dly[c] - 3'h1;
        end
      end
      light = ~r.cfg2[c];
      if (!r.on[c]) begin
        n.phase[c] = hss_pkg::HSS_PH_IDLE;
        n.wcnt[c] = '0;
      end else begin
        unique case (r.phase[c])
          hss_pkg::HSS_PH_IDLE: begin
            n.phase[c] = hss_pkg::HSS_PH_HIGH;
            n.wcnt[c] = win_len(light, r.oc[c][`HSS_OC_HWIN], r.oc[c][`HSS_OC_MWIN], 1'b0);
          end
          hss_pkg::HSS_PH_HIGH: begin
            if (r.wcnt[c] != '0) begin
              n.wcnt[c] = r.wcnt[c] - CW'(1);
            end else if (light) begin
              n.phase[c] = hss_pkg::HSS_PH_MID;
              n.wcnt[c] = win_len(light, r.oc[c][`HSS_OC_HWIN], r.oc[c][`HSS_OC_MWIN], 1'b1);
            end else begin
              n.phase[c] = hss_pkg::HSS_PH_LOW;
            end
          end
          hss_pkg::HSS_PH_MID: begin
            if (r.wcnt[c] != '0) begin
              n.wcnt[c] = r.wcnt[c] - CW'(1);
            end else begin
              n.phase[c] = hss_pkg::HSS_PH_LOW;
            end
          end
          hss_pkg::HSS_PH_LOW: n.phase[c] = hss_pkg::HSS_PH_LOW;
        endcase
      end
      n.short_en[c] = ~r.cc[c][`HSS_CC_SHORT_DIS];
      n.onol_en[c] = ~r.cc[c][`HSS_CC_ONOL_DIS] & r.on[c];
      n.offol_en[c] = ~r.cc[c][`HSS_CC_OFFOL_DIS] & ~r.on[c];
      n.slew[c] = slew_map(r.cc[c][`HSS_CC_SLEW_HI:`HSS_CC_SLEW_LO]);
      if (!r.oc[c][`HSS_OC_RANGE]) begin
        n.ocl_lvl[c] = `HSS_OCL_HIGHEST;
      end else if (r.oc[c][`HSS_OC_LOWER]) begin
        n.ocl_lvl[c] = `HSS_OCL_LOWEST;
      end else begin
        n.ocl_lvl[c] = `HSS_OCL_MIDDLE;
      end
      n.och_low[c] = r.oc[c][`HSS_OC_UPPER];
      n.ocm_low[c] = r.oc[c][`HSS_OC_MIDDLE] & light;
      // thresholds are not rescaled with it
      n.ratio_low[c] = r.oc[c][`HSS_OC_RATIO];
      n.sns_valid[c] = r.on[c] & (r.phase[c] == hss_pkg::HSS_PH_LOW);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{cc: {2{`HSS_CFG_RST}}, oc: {2{`HSS_CFG_RST}}, short_en: 2'h3,
             offol_en: 2'h3, slew: {2{hss_pkg::HSS_SLEW_MED}},
             ocl_lvl: {2{`HSS_OCL_HIGHEST}}, default: '0};
    end else begin
      r <= n;
    end
  end

  assign chan_on = r.on;
  assign short_detect_en = r.short_en;
  assign on_openload_en = r.onol_en;
  assign off_openload_en = r.offol_en;
  assign slew_rate = r.slew;
  assign oc_phase = r.phase;
  assign upper_threshold_low = r.och_low;
  assign middle_threshold_low = r.ocm_low;
  assign lower_threshold_level = r.ocl_lvl;
  assign sense_ratio_low = r.ratio_low;
  assign sense_valid = r.sns_valid;

  a_short_det_map: assert property (@(posedge sys_clk) disable iff (sys_rst)
    short_detect_en[1] == ~$past(r.cc[1][`HSS_CC_SHORT_DIS]))
    else $error("short detect enable does not follow its disable bit");

  a_onol_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    on_openload_en[0] |-> ($past(r.on[0]) && !$past(r.cc[0][`HSS_CC_ONOL_DIS])))
    else $error("on-state openload enabled while off or disabled");

  a_offol_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!r.on[1] && !r.cc[1][`HSS_CC_OFFOL_DIS]) |=> off_openload_en[1])
    else $error("off-state openload not enabled");

  a_direct_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!r.cc[0][`HSS_CC_DIR_DIS] && !r.dir2[0]) |=> !r.req[0] ##1 !chan_on[0])
    else $error("channel on while direct input low");

  a_slew_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (r.cc[0][`HSS_CC_SLEW_HI:`HSS_CC_SLEW_LO] == 2'b01) |=>
    slew_rate[0] == hss_pkg::HSS_SLEW_LOW)
    else $error("slew code 01 not decoded as low");

  a_bank_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rx_valid && rx_word[`HSS_BIT_BANK] &&
     rx_word[`HSS_ADDR_HI:`HSS_ADDR_LO] == `HSS_ADDR_CHCFG) |=>
    (r.cc[1] == $past(rx_word[8:0])) && $stable(r.cc[0]))
    else $error("write reached wrong channel copy");

  a_delay_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($rose(r.pend[0]) && r.dly[0] == 3'h0 && r.req[0]) |=> chan_on[0])
    else $error("zero turn-on delay not honoured");

  a_ocl_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (r.oc[1][`HSS_OC_RANGE] && r.oc[1][`HSS_OC_LOWER]) |=>
    lower_threshold_level[1] == `HSS_OCL_LOWEST)
    else $error("lowest threshold level wrong");

  a_sense_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (r.phase[0] != hss_pkg::HSS_PH_LOW) |=> !sense_valid[0])
    else $error("sense result during overcurrent window");

  a_prescale_cap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!r.oc[0][`HSS_OC_PRESCALE] && r.ediv[0] <= `HSS_DIV_SHORT) |=>
    r.ediv[0] <= `HSS_DIV_SHORT)
    else $error("external divider beyond 256 count");

endmodule
`default_nettype wire

/* File: dv/hss_host_model.sv */
// host controller model driving the serial configuration link
`timescale 1ns/1ps
`default_nettype none

module hss_host_model (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output logic      csb_pin,
  output logic      sclk_pin,
  output logic      si_pin,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    csb_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one frame, msb first; hold sets each sclk phase length
  // bank bit travels in word bit 13
  task automatic xfer(input logic [15:0] w, input int hold, output logic [15:0] r);
    tick(1);
    csb_pin = 1'b0;
    tick(hold);
    for (int i = 15; i >= 0; i--) begin
      si_pin = w[i];
      tick(hold);
      sclk_pin = 1'b1;
      r[i] = so_oe ? so_out : 1'bx;
      tick(hold);
      sclk_pin = 1'b0;
    end
    tick(hold);
    csb_pin = 1'b1;
    si_pin = ~si_pin;
    tick(hold + 6);
  endtask
endmodule
`default_nettype wire

/* File: dv/channel_protection_config_regs_test.sv */
// self-checking bench for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "hss_defs.svh"

module channel_protection_config_regs_test;
  // upper windows keep their default lengths of 1000 and 2000 cycles
  localparam int EHI[8] = '{1000, 1000, 2000, 2000, 5, 7, 1000, 2000};
  localparam int EMID[8] = '{8, 10, 8, 10, 0, 0, 0, 0};
  logic            sys_clk, sys_rst, csb_pin, sclk_pin, si_pin;
  logic            so_out, so_oe, ext_clk_pin;
  logic [1:0]      direct_in_pin, load_type_config, pwm_on, chan_on;
  logic [1:0]      short_detect_en, on_openload_en, off_openload_en;
  logic [1:0]      upper_threshold_low, middle_threshold_low;
  logic [1:0]      sense_ratio_low, sense_valid;
  logic [1:0][1:0] slew_rate, oc_phase, lower_threshold_level;
  logic [15:0]     rd;
  int              n_errors, checks_done;

  hss_chan_cfg #(.INT_DIV(4), .T_OCM1_L(8), .T_OCM2_L(10), .T_OCM1_M(5),
    .T_OCM2_M(7)) uut (.sys_clk, .sys_rst,
    .csb_pin, .sclk_pin, .si_pin, .so_out, .so_oe, .ext_clk_pin,
    .direct_in_pin, .load_type_config, .pwm_on, .chan_on, .short_detect_en,
    .on_openload_en, .off_openload_en, .slew_rate, .oc_phase,
    .upper_threshold_low, .middle_threshold_low, .lower_threshold_level,
    .sense_ratio_low, .sense_valid);

  hss_host_model host (.sys_clk, .csb_pin, .sclk_pin, .si_pin, .so_out, .so_oe);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    ext_clk_pin = 1'b0;
    forever @(negedge sys_clk) ext_clk_pin = ~ext_clk_pin;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic b, input logic [2:0] a, input logic [8:0] d);
    host.xfer({2'h0, b, a, 1'b0, d}, 4, rd);
  endtask

  // address the register, then read it in the following frame
  task automatic rdchk(input logic b, input logic [2:0] s, input logic [8:0] e);
    wr(b, `HSS_ADDR_STATUS, {6'h00, s});
    host.xfer({2'h0, b, `HSS_ADDR_STATUS, 7'h00, s}, 9, rd);
    chk(rd, {2'h0, b, s, 1'b1, e});
  endtask

  task automatic wait_on(input logic v, output int n);
    n = 0;
    while (chan_on[0] !== v) begin
      cyc(1);
      n++;
      if (n > 3000) begin
        n_errors++;
        close_out();
      end
    end
  endtask

  task automatic phase_len(input logic [1:0] p, output int n);
    n = 0;
    while (oc_phase[0] === p && n < 3000) begin
      chk(16'(sense_valid[0]), 16'h0);
      cyc(1);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      close_out();
    end
  endtask

  function automatic logic [1:0] slew_of(input logic [1:0] s);
    case (s)
      2'h0: return hss_pkg::HSS_SLEW_MED;
      2'h1: return hss_pkg::HSS_SLEW_LOW;
      2'h2: return hss_pkg::HSS_SLEW_HIGH;
      default: return hss_pkg::HSS_SLEW_MEDHI;
    endcase
  endfunction

  task automatic t_reset;
    chk(16'(short_detect_en), 16'h3);
    chk(16'(on_openload_en), 16'h0);
    chk(16'(off_openload_en), 16'h3);
    chk(16'(slew_rate), 16'({2{hss_pkg::HSS_SLEW_MED}}));
    chk(16'(lower_threshold_level), 16'({2{`HSS_OCL_HIGHEST}}));
    for (int b = 0; b < 2; b++) begin
      rdchk(b[0], `HSS_ADDR_CHCFG, `HSS_CFG_RST);
      rdchk(b[0], `HSS_ADDR_OCCFG, `HSS_CFG_RST);
    end
  endtask

  task automatic t_chcfg;
    wr(1'b0, 3'h6, 9'h1ff);
    for (int s = 0; s < 4; s++) begin
      wr(1'b1, `HSS_ADDR_CHCFG, {3'h7, 1'b0, s[1:0], 3'h5});
      chk(16'(short_detect_en), 16'h1);
      chk(16'(off_openload_en), 16'h1);
      chk(16'(slew_rate), 16'({slew_of(s[1:0]), hss_pkg::HSS_SLEW_MED}));
      rdchk(1'b1, `HSS_ADDR_CHCFG, {3'h7, 1'b0, s[1:0], 3'h5});
      rdchk(1'b0, `HSS_ADDR_CHCFG, 9'h000);
    end
    wr(1'b1, `HSS_ADDR_CHCFG, 9'h000);
  endtask

  task automatic t_occfg;
    logic [1:0] lv;
    for (int i = 0; i < 4; i++) begin
      lv = i[1] ? (i[0] ? `HSS_OCL_LOWEST : `HSS_OCL_MIDDLE) : `HSS_OCL_HIGHEST;
      wr(1'b0, `HSS_ADDR_OCCFG, {i[1], 2'h0, i[0], 2'h0, i[1], i[0], i[0]});
      chk(16'(lower_threshold_level), 16'({`HSS_OCL_HIGHEST, lv}));
      chk(16'(upper_threshold_low), 16'(i[1]));
      chk(16'(sense_ratio_low), 16'(i[0]));
      chk(16'(middle_threshold_low), 16'(i[0]));
      load_type_config = 2'h1;
      cyc(8);
      chk(16'(middle_threshold_low), 16'h0);
      load_type_config = 2'h0;
      cyc(8);
    end
  endtask

  task automatic t_window;
    int hi, mid, n;
    for (int k = 0; k < 8; k++) begin
      load_type_config = 2'(k / 4);
      wr(1'b0, `HSS_ADDR_OCCFG, {4'h0, 2'(k % 4), 3'h0});
      direct_in_pin = 2'h1;
      wait_on(1'b1, n);
      // window phase starts one cycle after the channel turns on
      cyc(1);
      phase_len(hss_pkg::HSS_PH_HIGH, hi);
      phase_len(hss_pkg::HSS_PH_MID, mid);
      chk(16'(hi), 16'(EHI[k]));
      chk(16'(mid), 16'(EMID[k]));
      chk(16'(oc_phase[0]), 16'(hss_pkg::HSS_PH_LOW));
      cyc(2);
      chk(16'(sense_valid), 16'h1);
      chk(16'(on_openload_en), 16'h1);
      chk(16'(off_openload_en), 16'h2);
      direct_in_pin = 2'h0;
      wait_on(1'b0, n);
      cyc(4);
    end
    load_type_config = 2'h0;
  endtask

  task automatic t_dirdis;
    int n;
    wr(1'b0, `HSS_ADDR_CHCFG, 9'h020);
    direct_in_pin = 2'h1;
    cyc(20);
    chk(16'(chan_on), 16'h0);
    pwm_on = 2'h1;
    wait_on(1'b1, n);
    chk(16'(n < 10), 16'h1);
    pwm_on = 2'h0;
    wait_on(1'b0, n);
    direct_in_pin = 2'h0;
    cyc(4);
  endtask

  task automatic lat(input logic [8:0] oc, input logic [2:0] d, output int n);
    int m;
    wr(1'b0, `HSS_ADDR_OCCFG, oc);
    wr(1'b0, `HSS_ADDR_CHCFG, {6'h04, d});
    pwm_on = 2'h1;
    wait_on(1'b1, n);
    pwm_on = 2'h0;
    wait_on(1'b0, m);
    cyc(4);
  endtask

  task automatic t_delay;
    int b0, n;
    lat(9'h040, 3'h0, b0);
    lat(9'h040, 3'h3, n);
    chk(16'(n - b0 >= 8 && n - b0 <= 14), 16'h1);
    lat(9'h000, 3'h2, n);
    chk(16'(n - b0 >= 512 && n - b0 <= 1030), 16'h1);
    lat(9'h080, 3'h2, n);
    chk(16'(n - b0 >= 1024 && n - b0 <= 2060), 16'h1);
  endtask

  initial begin
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    direct_in_pin = 2'h0;
    load_type_config = 2'h0;
    pwm_on = 2'h0;
    cyc(10);
    sys_rst = 1'b0;
    cyc(2);
    t_reset();
    t_chcfg();
    t_occfg();
    t_window();
    t_dirdis();
    t_delay();
    close_out();
  end
endmodule
`default_nettype wire
